// ===== src/rx_port_bcc_pkg.sv
// constants for the per-port return-link configuration bank
// assumes an 8-bit register access port driven by the local i2c target logic
package rx_port_bcc_pkg;

  localparam int          num_ports          = 4;
  localparam int          port_sel_bits      = 2;

  localparam logic [7:0]  port_select_addr   = 8'h4C;
  localparam logic [7:0]  back_channel_addr  = 8'h58;
  localparam logic [7:0]  datapath_one_addr  = 8'h59;
  localparam logic [7:0]  serializer_id_addr = 8'h5B;

  // back_channel_config fields
  localparam int          pass_all_bit       = 7;
  localparam int          pass_decoded_bit   = 6;
  localparam int          ack_all_bit        = 5;
  localparam int          always_on_bit      = 4;
  localparam int          crc_enable_bit     = 3;
  localparam logic [7:0]  bcc_reset_upper    = 8'h18;
  localparam logic [2:0]  rate_2p5_mbps      = 3'h0;
  localparam logic [2:0]  rate_10_mbps       = 3'h2;

  // datapath_control_one fields
  localparam int          hold_local_bit     = 7;
  localparam logic [7:0]  datapath_reset     = 8'h00;
  localparam logic [7:0]  datapath_rw_mask   = 8'h83;

  // remote_serializer_ident fields
  localparam int          hold_ident_bit     = 0;
  localparam logic [7:0]  ident_reset        = 8'h00;

  localparam logic [7:0]  port_select_reset  = 8'h00;

endpackage : rx_port_bcc_pkg

// ===== src/rx_port_back_channel_config.sv
// per-receive-port return-link config: bcc, datapath control, serializer ident
// assumes reg_wr/reg_rd are one-cycle strobes from i2c target logic on core_clk;
// remote-loaded values arrive as strobes on core_clk; rate strap is a pin.
`timescale 1ns/1ps

module rx_port_back_channel_config #(
  parameter int ports       = rx_port_bcc_pkg::num_ports,
  parameter int settle_cyc  = 64
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic [2:0]          rate_strap,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic                reg_from_local,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output      logic [7:0]          reg_rdata,
  input  wire logic [ports-1:0]    remote_gpio_load,
  input  wire logic [ports*2-1:0]  remote_gpio_count,
  input  wire logic [ports-1:0]    remote_ident_load,
  input  wire logic [ports*7-1:0]  remote_ident,
  input  wire logic [ports-1:0]    i2c_addr_match,
  input  wire logic [ports-1:0]    i2c_txn_valid,
  input  wire logic [ports-1:0]    i2c_txn_write,
  output      logic [ports-1:0]    forward_txn,
  output      logic [ports-1:0]    local_ack,
  output      logic [ports-1:0]    return_link_enable,
  output      logic [ports-1:0]    return_link_crc_enable,
  output      logic [ports*3-1:0]  return_link_rate_select,
  output      logic [ports-1:0]    return_link_rate_invalid,
  output      logic [ports-1:0]    return_link_settling,
  output      logic [ports*2-1:0]  forward_gpio_count,
  output      logic [ports*4-1:0]  forward_gpio_enable,
  output      logic [ports*7-1:0]  remote_serializer_ident
);

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser, three stages

  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [2:0] strap_s3;
  logic       strap_taken;

  always_ff @(posedge core_clk) begin
    strap_s1 <= rate_strap;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  wire strap_stable = (strap_s2 == strap_s3);

  ////////////////////////////////////////////////////////////////////////////
  // port select and address decode

  logic [7:0] port_select;

  wire sel_port_hit = (reg_addr == rx_port_bcc_pkg::port_select_addr);
  wire sel_bcc_hit  = (reg_addr == rx_port_bcc_pkg::back_channel_addr);
  wire sel_dp_hit   = (reg_addr == rx_port_bcc_pkg::datapath_one_addr);
  wire sel_id_hit   = (reg_addr == rx_port_bcc_pkg::serializer_id_addr);
  wire [rx_port_bcc_pkg::port_sel_bits-1:0] cur_port =
    port_select[rx_port_bcc_pkg::port_sel_bits-1:0];

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      port_select <= rx_port_bcc_pkg::port_select_reset;
    end else if (reg_wr && sel_port_hit) begin
      port_select <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port register copies

  logic [7:0] bcc      [ports];
  logic [7:0] datapath [ports];
  logic [7:0] ident    [ports];
  logic [7:0] rd_bcc;
  logic [7:0] rd_dp;
  logic [7:0] rd_id;

  // strap captured once after release; reset itself only loads constants
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strap_taken <= 1'b0;
    end else if (strap_stable) begin
      strap_taken <= 1'b1;
    end
  end

  wire strap_load = !strap_taken && strap_stable;

  genvar p;
  generate
    for (p = 0; p < ports; p++) begin : g_port
      // a genvar cannot be part-selected, so size it by a cast instead
      wire       here   = (cur_port == rx_port_bcc_pkg::port_sel_bits'(p));
      wire       wr_bcc = reg_wr && sel_bcc_hit && here;
      wire       wr_dp  = reg_wr && sel_dp_hit && here;
      wire       wr_id  = reg_wr && sel_id_hit && here;
      wire       held   = datapath[p][rx_port_bcc_pkg::hold_local_bit];
      wire       idheld = ident[p][rx_port_bcc_pkg::hold_ident_bit];
      // remote writes cannot touch always-on
      wire       ao_val = reg_from_local ? reg_wdata[rx_port_bcc_pkg::always_on_bit]
                                         : bcc[p][rx_port_bcc_pkg::always_on_bit];
      wire [7:0] bcc_wr = {reg_wdata[7:5], ao_val, reg_wdata[3:0]};
      wire [2:0] rate   = bcc[p][2:0];
      wire       pass_all = bcc[p][rx_port_bcc_pkg::pass_all_bit];
      wire       pass_dec = bcc[p][rx_port_bcc_pkg::pass_decoded_bit];
      wire [1:0] gcount = datapath[p][1:0];
      logic [$clog2(settle_cyc+1)-1:0] settle;

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          bcc[p] <= rx_port_bcc_pkg::bcc_reset_upper;
        end else if (wr_bcc) begin
          bcc[p] <= bcc_wr;
        end else if (strap_load) begin
          bcc[p] <= {bcc[p][7:3], strap_s3};
        end
      end

      // local write to gpio count sticks only while held; loads skip when held
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          datapath[p] <= rx_port_bcc_pkg::datapath_reset;
        end else if (wr_dp) begin
          datapath[p][7] <= reg_wdata[rx_port_bcc_pkg::hold_local_bit];
          if (reg_wdata[rx_port_bcc_pkg::hold_local_bit] || held) begin
            datapath[p][1:0] <= reg_wdata[1:0];
          end
        end else if (remote_gpio_load[p] && !held) begin
          datapath[p][1:0] <= remote_gpio_count[p*2 +: 2];
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          ident[p] <= rx_port_bcc_pkg::ident_reset;
        end else if (wr_id) begin
          ident[p] <= reg_wdata;
        end else if (remote_ident_load[p] && !idheld) begin
          ident[p][7:1] <= remote_ident[p*7 +: 7];
        end
      end

      // transient error window after a register write changes the rate
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          settle <= '0;
        end else if (wr_bcc && (bcc_wr[2:0] != rate)) begin
          settle <= ($clog2(settle_cyc+1))'(settle_cyc);
        end else if (settle != '0) begin
          settle <= settle - 1'b1;
        end
      end

      assign return_link_settling[p]     = (settle != '0);
      assign forward_txn[p]              = i2c_txn_valid[p] &&
                                           (pass_all || (pass_dec && i2c_addr_match[p]));
      assign local_ack[p]                = forward_txn[p] && i2c_txn_write[p] &&
                                           bcc[p][rx_port_bcc_pkg::ack_all_bit];
      assign return_link_enable[p]       = bcc[p][rx_port_bcc_pkg::always_on_bit] ||
                                           pass_all || pass_dec;
      assign return_link_crc_enable[p]   = bcc[p][rx_port_bcc_pkg::crc_enable_bit];
      assign return_link_rate_select[p*3 +: 3] = rate;
      assign return_link_rate_invalid[p] = (rate != rx_port_bcc_pkg::rate_2p5_mbps) &&
                                           (rate != rx_port_bcc_pkg::rate_10_mbps);
      assign forward_gpio_count[p*2 +: 2] = gcount;
      assign forward_gpio_enable[p*4 +: 4] = (gcount == 2'h0) ? 4'h0 :
                                             (gcount == 2'h1) ? 4'h1 :
                                             (gcount == 2'h2) ? 4'h3 : 4'hF;
      assign remote_serializer_ident[p*7 +: 7] = ident[p][7:1];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped addresses read zero, reserved bits zero

  assign rd_bcc = bcc[cur_port];
  assign rd_dp  = datapath[cur_port] & rx_port_bcc_pkg::datapath_rw_mask;
  assign rd_id  = ident[cur_port];

  wire [7:0] rd_mux = sel_port_hit ? port_select :
                      sel_bcc_hit  ? rd_bcc :
                      sel_dp_hit   ? rd_dp :
                      sel_id_hit   ? rd_id : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule : rx_port_back_channel_config

// ===== dv/rx_port_bcc_properties.sv
// checker: port relations of the return-link config bank
// assumes bind onto rx_port_back_channel_config, one clock domain
`timescale 1ns/1ps
module rx_port_bcc_properties #(
  parameter int ports = 4
) (
  input wire logic               core_clk, rstn, reg_wr,
  input wire logic [7:0]         reg_addr,
  input wire logic [ports-1:0]   remote_ident_load, i2c_txn_valid, i2c_txn_write,
  input wire logic [ports-1:0]   forward_txn, local_ack, return_link_enable,
  input wire logic [ports-1:0]   return_link_crc_enable, return_link_rate_invalid,
  input wire logic [ports-1:0]   return_link_settling,
  input wire logic [ports*3-1:0] return_link_rate_select,
  input wire logic [ports*2-1:0] forward_gpio_count,
  input wire logic [ports*4-1:0] forward_gpio_enable,
  input wire logic [ports*7-1:0] remote_serializer_ident
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////
  localparam logic [15:0] gpio_map = 16'hF310;
  sequence s_rate_wr;
    reg_wr && reg_addr == 8'h58 ##1 return_link_rate_select != $past(return_link_rate_select);
  endsequence
  property p_fwd; (forward_txn & ~i2c_txn_valid) == '0; endproperty
  a_fwd: assert property (p_fwd) else $error("forward without txn");
  property p_rle; (forward_txn & ~return_link_enable) == '0; endproperty
  a_rle: assert property (p_rle) else $error("forward with link off");
  property p_ack; (local_ack & ~(forward_txn & i2c_txn_write)) == '0; endproperty
  a_ack: assert property (p_ack) else $error("stray local ack");
  property p_rst; $rose(rstn) |-> &return_link_enable && &return_link_crc_enable; endproperty
  a_rst: assert property (p_rst) else $error("bad reset enables");
  property p_inv;
    return_link_rate_invalid[0] == !(return_link_rate_select[2:0] inside {3'h0, 3'h2});
  endproperty
  a_inv: assert property (p_inv) else $error("bad rate flag");
  property p_settle; s_rate_wr |-> |return_link_settling; endproperty
  a_settle: assert property (p_settle) else $error("no settle window");
  property p_gpio; forward_gpio_enable[11:8] == gpio_map[forward_gpio_count[5:4]*4 +: 4];
  endproperty
  a_gpio: assert property (p_gpio) else $error("bad gpio decode");
  // reset clears the ident, so only judge edges with reset high on both sides
  property p_ident; $past(rstn) && $changed(remote_serializer_ident)
    |-> $past(reg_wr) || $past(remote_ident_load) != '0; endproperty
  a_ident: assert property (p_ident) else $error("ident changed uncaused");
endmodule : rx_port_bcc_properties
bind rx_port_back_channel_config rx_port_bcc_properties #(.ports(ports)) u_props (.*);

// ===== dv/remote_serializer_model.sv
// far-side model: pushes gpio count and ident over the forward channel
// assumes tb calls send() at 5 ns past a rising edge
`timescale 1ns/1ps
module remote_serializer_model #(
  parameter int ports = 4
) (
  input  wire logic           core_clk,
  output logic [ports-1:0]    gpio_load, ident_load,
  output logic [ports*2-1:0]  gpio_count,
  output logic [ports*7-1:0]  ident
);
  initial begin
    {gpio_load, ident_load, gpio_count, ident} = '0;
  end
  //////////////////////////////
  task automatic send(input int p, input logic [1:0] g, input logic [6:0] id);
    @(posedge core_clk);
    #5;
    {gpio_load[p], ident_load[p], gpio_count[p*2 +: 2], ident[p*7 +: 7]} = {2'b11, g, id};
    @(posedge core_clk);
    #5;
    {gpio_load, ident_load} = '0;
    // data invalid once released: invert so stale values cannot pass
    gpio_count = ~gpio_count;
    ident = ~ident;
  endtask : send
endmodule : remote_serializer_model

// ===== dv/tb_rx_port_back_channel_config.sv
// bench for the return-link config bank, one task per scenario
// assumes package, design, partner model and checker compiled first
`timescale 1ns/1ps
module tb_rx_port_back_channel_config;
  logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, loc = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, g_in, gcnt;
  logic [3:0] match = 4'h0, valid = 4'hF, wrt = 4'hF, fwd, ack, rle, crc, inv, settle;
  logic [3:0] g_ld, id_ld;
  logic [11:0] rate;
  logic [15:0] gen;
  logic [27:0] id_in, ident;
  logic [7:0] modes [3] = '{8'h02, 8'h42, 8'hA2};
  int n_fail = 0, samples_checked = 0;
  rx_port_back_channel_config #(.ports(4), .settle_cyc(4)) uut (
    .core_clk(core_clk), .rstn(rstn), .rate_strap(3'h2), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_from_local(loc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .remote_gpio_load(g_ld), .remote_gpio_count(g_in), .remote_ident_load(id_ld),
    .remote_ident(id_in), .i2c_addr_match(match), .i2c_txn_valid(valid),
    .i2c_txn_write(wrt), .forward_txn(fwd), .local_ack(ack), .return_link_enable(rle),
    .return_link_crc_enable(crc), .return_link_rate_select(rate),
    .return_link_rate_invalid(inv), .return_link_settling(settle),
    .forward_gpio_count(gcnt), .forward_gpio_enable(gen), .remote_serializer_ident(ident));
  remote_serializer_model #(.ports(4)) ser (.core_clk(core_clk), .gpio_load(g_ld),
    .ident_load(id_ld), .gpio_count(g_in), .ident(id_in));
  //////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic l);
    @(posedge core_clk);
    #5;
    {reg_wr, reg_addr, reg_wdata, loc} = {1'b1, a, d, l};
    @(posedge core_clk);
    #5;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #5;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge core_clk);
    #5;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #5;
    check(reg_rdata, exp);
  endtask : rdc
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic t_pass;
    logic [7:0] m;
    wr(8'h4C, 8'h01, 1'b1);
    for (int i = 0; i < 6; i++) begin
      m = modes[i/2];
      wr(8'h58, m, 1'b1);
      match = {4{i[0]}};
      #1;
      check(8'(fwd), 8'({m[7] | (m[6] & i[0]), 1'b0}));
      check(8'(ack), 8'({(m[7] | (m[6] & i[0])) & m[5], 1'b0}));
      check(8'(rle), 8'({2'b11, m[7] | m[6], 1'b1}));
    end
  endtask : t_pass
  task automatic t_rate;
    int n;
    wr(8'h58, 8'h10, 1'b1);
    wr(8'h58, 8'h00, 1'b0);
    rdc(8'h58, 8'h10);
    check(8'(crc), 8'h0D);
    wr(8'h58, 8'h30, 1'b0);
    wr(8'h58, 8'h22, 1'b0);
    check(8'(settle[1]), 8'h01);
    check(8'(rate[5:3]), 8'h02);
    check(8'(inv), 8'h00);
    for (n = 0; n < 20 && settle[1] !== 1'b0; n++) @(posedge core_clk);
    if (n == 20) begin
      n_fail++;
      finish_test();
    end
    wr(8'h58, 8'h31, 1'b1);
    rdc(8'h58, 8'h31);
    check(8'(inv), 8'h02);
  endtask : t_rate
  task automatic t_remote;
    wr(8'h4C, 8'h02, 1'b1);
    wr(8'h59, 8'h03, 1'b1);
    rdc(8'h59, 8'h00);
    ser.send(2, 2'h2, 7'h00);
    rdc(8'h59, 8'h02);
    check(8'(gen[11:8]), 8'h03);
    check(8'(gcnt[5:4]), 8'h02);
    wr(8'h59, 8'h83, 1'b1);
    ser.send(2, 2'h1, 7'h00);
    rdc(8'h59, 8'h83);
    check(8'(gen[11:8]), 8'h0F);
    check(8'(gcnt[5:4]), 8'h03);
    wr(8'h4C, 8'h03, 1'b1);
    ser.send(3, 2'h0, 7'h55);
    rdc(8'h5B, 8'hAA);
    check(8'(ident[27:21]), 8'h55);
    wr(8'h5B, 8'h13, 1'b1);
    ser.send(3, 2'h0, 7'h7F);
    rdc(8'h5B, 8'h13);
  endtask : t_remote
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #5;
    rstn = 1'b1;
    // strap is synchronised during reset and loaded on the first clock after release
    repeat (6) @(posedge core_clk);
    rdc(8'h58, rx_port_bcc_pkg::bcc_reset_upper | 8'h02);
    rdc(8'h59, 8'h00);
    rdc(8'h5A, 8'h00);
    t_pass();
    t_rate();
    t_remote();
    finish_test();
  end
endmodule : tb_rx_port_back_channel_config
